// ==== logic/memory_map_pkg.sv ====
// Package of address map constants, target codes and bus carriers for the memory map decoder.
// Summary of operation
// - Two layouts: external space 0 at zero, or on-chip program memory at zero.
// - Layout loaded at reset from boot pins, then software-writable; board holds pins during reset.
// - Five boot bits are taken from the low five expansion bus data pins.
// - Layout bit in external memory global control steers spaces 0 and 1.
// - Low 384 KB is space 0 or program memory; program memory otherwise at 0140_0000.
// - 0200_0000..02FF_FFFF is external space 2, controlled at 0180_0010.
// - 0300_0000..03FF_FFFF is external space 3, controlled at 0180_0014.
// - External memory window selects global, space, DRAM and refresh registers.
// - 0180_000C reserved; 0180_0020..0183_FFFF select no register.
// - Channel registers interleave: channels 0/2 from 0184_0000, channels 1/3 from 0184_0040.
// - Shared reload, index and address registers decode at their fixed offsets.
// - Auxiliary control at 0184_0070; 0184_0074..0187_FFFF select no register.
// - Peripheral windows decode at fixed word-aligned addresses or ranges.
// - Expansion spaces 2 and 3 decode at 6000_0000 and 7000_0000, 256 MB each.
package memory_map_pkg;

    // ------------------------------------------------------------
    // Targets
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        tgt_none      = 5'h00,
        tgt_prog_mem  = 5'h01,
        tgt_space0    = 5'h02,
        tgt_space1    = 5'h03,
        tgt_space2    = 5'h04,
        tgt_space3    = 5'h05,
        tgt_ext_regs  = 5'h06,
        tgt_dma_regs  = 5'h07,
        tgt_xbus_regs = 5'h08,
        tgt_serial0   = 5'h09,
        tgt_serial1   = 5'h0A,
        tgt_timer0    = 5'h0B,
        tgt_timer1    = 5'h0C,
        tgt_irq_sel   = 5'h0D,
        tgt_power     = 5'h0E,
        tgt_serial2   = 5'h0F,
        tgt_xbus0     = 5'h10,
        tgt_xbus1     = 5'h11,
        tgt_xbus2     = 5'h12,
        tgt_xbus3     = 5'h13,
        tgt_data_mem  = 5'h14
    } target_e;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } access_s;

    typedef struct packed {
        target_e     target;
        logic [5:0]  reg_index;
        logic        reg_hit;
    } select_s;

    // ------------------------------------------------------------
    // Address ranges (inclusive bounds)
    // ------------------------------------------------------------
    localparam logic [31:0] low_base      = 32'h0000_0000;
    localparam logic [31:0] low_prog_top  = 32'h0005_FFFF;
    localparam logic [31:0] low_res_top   = 32'h003F_FFFF;
    localparam logic [31:0] low_sp0_top   = 32'h00FF_FFFF;
    localparam logic [31:0] mid_top       = 32'h013F_FFFF;
    localparam logic [31:0] hi_prog_base  = 32'h0140_0000;
    localparam logic [31:0] hi_prog_top   = 32'h0145_FFFF;
    localparam logic [31:0] hi_res_top    = 32'h017F_FFFF;
    localparam logic [31:0] ext_base      = 32'h0180_0000;
    localparam logic [31:0] ext_top       = 32'h0183_FFFF;
    localparam logic [31:0] dma_base      = 32'h0184_0000;
    localparam logic [31:0] dma_top       = 32'h0187_FFFF;
    localparam logic [31:0] xbreg_top     = 32'h018B_FFFF;
    localparam logic [31:0] ser0_top      = 32'h018F_FFFF;
    localparam logic [31:0] ser1_top      = 32'h0193_FFFF;
    localparam logic [31:0] tim0_top      = 32'h0197_FFFF;
    localparam logic [31:0] tim1_top      = 32'h019B_FFFF;
    localparam logic [31:0] irq_top       = 32'h019C_01FF;
    localparam logic [31:0] pwr_top       = 32'h019F_FFFF;
    localparam logic [31:0] gap_top       = 32'h01A3_FFFF;
    localparam logic [31:0] ser2_top      = 32'h01A7_FFFF;
    localparam logic [31:0] sp2_base      = 32'h0200_0000;
    localparam logic [31:0] sp2_top       = 32'h02FF_FFFF;
    localparam logic [31:0] sp3_top       = 32'h03FF_FFFF;
    localparam logic [31:0] xb0_base      = 32'h4000_0000;
    localparam logic [31:0] xb1_base      = 32'h5000_0000;
    localparam logic [31:0] xb2_base      = 32'h6000_0000;
    localparam logic [31:0] xb3_base      = 32'h7000_0000;
    localparam logic [31:0] xb3_top       = 32'h7FFF_FFFF;
    localparam logic [31:0] dmem_base     = 32'h8000_0000;
    localparam logic [31:0] dmem_top      = 32'h8007_FFFF;

    // ------------------------------------------------------------
    // Register window offsets (byte offsets inside each window)
    // ------------------------------------------------------------
    localparam logic [17:0] ext_reserved_off  = 18'h0_000C;
    localparam logic [17:0] ext_last_off      = 18'h0_001C;
    localparam logic [17:0] dma_last_off      = 18'h0_0070;
    localparam logic [5:0]  reg_index_none    = 6'h3F;

    // ------------------------------------------------------------
    // Own APB registers and fields
    // ------------------------------------------------------------
    localparam logic [31:0] global_control_addr = 32'h0180_0000;
    localparam logic [31:0] decode_status_addr  = 32'h0180_0040;
    localparam logic [31:0] probe_addr_addr     = 32'h0180_0044;
    localparam int          layout_bit          = 5;
    localparam int          boot_width          = 5;
    localparam int          status_target_lsb   = 8;
    localparam logic [31:0] global_control_rst  = 32'h0000_0000;

endpackage : memory_map_pkg

// ==== logic/memory_map_address_decoder.sv ====
// Memory map address decoder with register window selects and an APB register slave.
`timescale 1ns/10ps
module memory_map_address_decoder (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [4:0]                    xbus_data_low_pins,
    input  wire memory_map_pkg::access_s       core_access,
    input  wire memory_map_pkg::access_s       dma_access,
    output      memory_map_pkg::select_s       core_select,
    output      memory_map_pkg::select_s       dma_select,
    output      logic                          layout_r,
    output      logic [4:0]                    boot_config_bits,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output      logic [31:0]                   prdata,
    output      logic                          pready,
    output      logic                          pslverr
);

    // ------------------------------------------------------------
    // Decode function
    // ------------------------------------------------------------
    function automatic memory_map_pkg::select_s decode(input logic [31:0] a, input logic map1);
        memory_map_pkg::select_s s;
        logic [17:0]             off;
        s         = '{target: memory_map_pkg::tgt_none, reg_index: memory_map_pkg::reg_index_none, reg_hit: 1'b0};
        off       = a[17:0];
        // Compare chain gives one target per address, so selects never overlap.
        if (a <= memory_map_pkg::low_prog_top) begin
            s.target = map1 ? memory_map_pkg::tgt_prog_mem : memory_map_pkg::tgt_space0;
        end else if (a <= memory_map_pkg::low_res_top) begin
            s.target = map1 ? memory_map_pkg::tgt_none : memory_map_pkg::tgt_space0;
        end else if (a <= memory_map_pkg::low_sp0_top) begin
            s.target = memory_map_pkg::tgt_space0;
        end else if (a <= memory_map_pkg::mid_top) begin
            s.target = map1 ? memory_map_pkg::tgt_space0 : memory_map_pkg::tgt_space1;
        end else if (a >= memory_map_pkg::hi_prog_base && a <= memory_map_pkg::hi_prog_top) begin
            s.target = map1 ? memory_map_pkg::tgt_space1 : memory_map_pkg::tgt_prog_mem;
        end else if (a <= memory_map_pkg::hi_res_top) begin
            s.target = map1 ? memory_map_pkg::tgt_space1 : memory_map_pkg::tgt_none;
        end else if (a <= memory_map_pkg::ext_top) begin
            s.target = memory_map_pkg::tgt_ext_regs;
            // Word-aligned offsets up to the refresh register, skipping the hole.
            if (off <= memory_map_pkg::ext_last_off && off[1:0] == 2'b00
                && off != memory_map_pkg::ext_reserved_off) begin
                s.reg_index = {1'b0, off[6:2]};
                s.reg_hit   = 1'b1;
            end
        end else if (a <= memory_map_pkg::dma_top) begin
            s.target = memory_map_pkg::tgt_dma_regs;
            // Index is the word number; channel interleave falls out of the offset.
            if (off <= memory_map_pkg::dma_last_off && off[1:0] == 2'b00) begin
                s.reg_index = off[7:2];
                s.reg_hit   = 1'b1;
            end
        end else if (a <= memory_map_pkg::xbreg_top) begin
            s.target = memory_map_pkg::tgt_xbus_regs;
        end else if (a <= memory_map_pkg::ser0_top) begin
            s.target = memory_map_pkg::tgt_serial0;
        end else if (a <= memory_map_pkg::ser1_top) begin
            s.target = memory_map_pkg::tgt_serial1;
        end else if (a <= memory_map_pkg::tim0_top) begin
            s.target = memory_map_pkg::tgt_timer0;
        end else if (a <= memory_map_pkg::tim1_top) begin
            s.target = memory_map_pkg::tgt_timer1;
        end else if (a <= memory_map_pkg::irq_top) begin
            s.target = memory_map_pkg::tgt_irq_sel;
        end else if (a <= memory_map_pkg::pwr_top) begin
            s.target = memory_map_pkg::tgt_power;
        end else if (a <= memory_map_pkg::gap_top) begin
            s.target = memory_map_pkg::tgt_none;
        end else if (a <= memory_map_pkg::ser2_top) begin
            s.target = memory_map_pkg::tgt_serial2;
        end else if (a < memory_map_pkg::sp2_base) begin
            s.target = memory_map_pkg::tgt_none;
        end else if (a <= memory_map_pkg::sp2_top) begin
            s.target = memory_map_pkg::tgt_space2;
        end else if (a <= memory_map_pkg::sp3_top) begin
            s.target = memory_map_pkg::tgt_space3;
        end else if (a < memory_map_pkg::xb0_base) begin
            s.target = memory_map_pkg::tgt_none;
        end else if (a < memory_map_pkg::xb1_base) begin
            s.target = memory_map_pkg::tgt_xbus0;
        end else if (a < memory_map_pkg::xb2_base) begin
            s.target = memory_map_pkg::tgt_xbus1;
        end else if (a < memory_map_pkg::xb3_base) begin
            s.target = memory_map_pkg::tgt_xbus2;
        end else if (a <= memory_map_pkg::xb3_top) begin
            s.target = memory_map_pkg::tgt_xbus3;
        end else if (a <= memory_map_pkg::dmem_top) begin
            s.target = memory_map_pkg::tgt_data_mem;
        end
        return s;
    endfunction : decode

    // ------------------------------------------------------------
    // Boot pin capture
    // ------------------------------------------------------------
    logic [4:0] boot_meta_r;
    logic [4:0] boot_sync_r;
    logic       boot_taken_r;
    logic [31:0] global_control_r;
    logic [31:0] probe_addr_r;

    always_ff @(posedge clk) begin
        boot_meta_r <= xbus_data_low_pins;
        boot_sync_r <= boot_meta_r;
    end

    // Pins pass two flops and are captured once, on the first cycle after reset release.
    always_ff @(posedge clk) begin
        if (srst) begin
            boot_taken_r     <= 1'b0;
            boot_config_bits <= 5'h00;
        end else if (!boot_taken_r) begin
            boot_taken_r     <= 1'b1;
            boot_config_bits <= boot_sync_r;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic apb_access;
    logic apb_write;
    assign apb_access = psel && penable && pready;
    assign apb_write  = apb_access && pwrite;

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // Layout bit loads from the strap once, then software may change it.
    always_ff @(posedge clk) begin
        if (srst) begin
            global_control_r <= memory_map_pkg::global_control_rst;
        end else if (!boot_taken_r) begin
            global_control_r[memory_map_pkg::layout_bit] <= boot_sync_r[0];
        end else if (apb_write && paddr == memory_map_pkg::global_control_addr) begin
            global_control_r <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            probe_addr_r <= 32'h0000_0000;
        end else if (apb_write && paddr == memory_map_pkg::probe_addr_addr) begin
            probe_addr_r <= pwdata;
        end
    end

    memory_map_pkg::select_s probe_sel;
    assign probe_sel = decode(probe_addr_r, global_control_r[memory_map_pkg::layout_bit]);

    // Unmapped addresses read zero and ignore writes, with no error.
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    memory_map_pkg::global_control_addr: prdata <= global_control_r;
                    memory_map_pkg::probe_addr_addr:     prdata <= probe_addr_r;
                    memory_map_pkg::decode_status_addr: begin
                        prdata <= {16'h0000, 3'b000, probe_sel.target, probe_sel.reg_hit, 1'b0,
                                   probe_sel.reg_index};
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // Registered selects cost one cycle of latency but keep outputs glitch free.
    always_ff @(posedge clk) begin
        if (srst) begin
            core_select <= '{target: memory_map_pkg::tgt_none, reg_index: memory_map_pkg::reg_index_none,
                             reg_hit: 1'b0};
            dma_select  <= '{target: memory_map_pkg::tgt_none, reg_index: memory_map_pkg::reg_index_none,
                             reg_hit: 1'b0};
            layout_r    <= 1'b0;
        end else begin
            layout_r <= global_control_r[memory_map_pkg::layout_bit];
            core_select <= core_access.valid
                ? decode(core_access.addr, global_control_r[memory_map_pkg::layout_bit])
                : '{target: memory_map_pkg::tgt_none, reg_index: memory_map_pkg::reg_index_none, reg_hit: 1'b0};
            dma_select  <= dma_access.valid
                ? decode(dma_access.addr, global_control_r[memory_map_pkg::layout_bit])
                : '{target: memory_map_pkg::tgt_none, reg_index: memory_map_pkg::reg_index_none, reg_hit: 1'b0};
        end
    end

endmodule : memory_map_address_decoder

// ==== verification/memory_map_address_decoder_assertions.sv ====
// Concurrent checks on the address decoder ports, bound to the decoder.
`timescale 1ns/10ps
module memory_map_address_decoder_assertions (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire logic [4:0]               xbus_data_low_pins,
    input wire memory_map_pkg::access_s  core_access,
    input wire memory_map_pkg::access_s  dma_access,
    input wire memory_map_pkg::select_s  core_select,
    input wire memory_map_pkg::select_s  dma_select,
    input wire logic                     layout_r,
    input wire logic [4:0]               boot_config_bits
);
    // ------------------------------------------------------------
    // Boot capture and decode checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Straps pass two flops before capture, and the layout copy lags the capture by one more edge.
    chk_boot_capture: assert property ($fell(srst) |=>
        boot_config_bits == $past(xbus_data_low_pins, 3) ##1 layout_r == $past(xbus_data_low_pins[0], 4))
        else $error("boot capture");
    chk_low_layout: assert property (core_access.valid && core_access.addr <= 32'h0005_FFFF |=>
        core_select.target == (layout_r ? memory_map_pkg::tgt_prog_mem : memory_map_pkg::tgt_space0))
        else $error("low space decode");
    chk_space2_decode: assert property (core_access.valid && core_access.addr[31:24] == 8'h02 |=>
        core_select.target == memory_map_pkg::tgt_space2) else $error("space 2 decode");
    chk_space3_decode: assert property (dma_access.valid && dma_access.addr[31:24] == 8'h03 |=>
        dma_select.target == memory_map_pkg::tgt_space3) else $error("space 3 decode");
    chk_xbus_spaces: assert property (core_access.valid && core_access.addr[31:29] == 3'b011 |=>
        core_select.target == ($past(core_access.addr[28]) ? memory_map_pkg::tgt_xbus3 : memory_map_pkg::tgt_xbus2))
        else $error("expansion space decode");
    chk_window_index: assert property (core_access.valid && core_access.addr[31:18] == 14'h0061 &&
        core_access.addr[17:0] <= 18'h0_0070 && core_access.addr[1:0] == 2'b00 |=>
        core_select.reg_hit && core_select.reg_index == $past(core_access.addr[7:2])) else $error("channel index");
    chk_extreg_gap: assert property (core_access.valid && core_access.addr[31:18] == 14'h0060 &&
        (core_access.addr[17:0] == 18'h0_000C || core_access.addr[17:0] >= 18'h0_0020) |=>
        !core_select.reg_hit) else $error("reserved register hit");
    chk_hole_none: assert property (dma_access.valid && dma_access.addr >= 32'h0400_0000 &&
        dma_access.addr <= 32'h3FFF_FFFF |=> dma_select.target == memory_map_pkg::tgt_none) else $error("hole selected");
    chk_idle_none: assert property (!core_access.valid |=>
        core_select.target == memory_map_pkg::tgt_none && !core_select.reg_hit) else $error("idle select");
endmodule : memory_map_address_decoder_assertions

bind memory_map_address_decoder memory_map_address_decoder_assertions i_chk (.clk(clk), .srst(srst),
    .xbus_data_low_pins(xbus_data_low_pins), .core_access(core_access), .dma_access(dma_access),
    .core_select(core_select), .dma_select(dma_select), .layout_r(layout_r), .boot_config_bits(boot_config_bits));

// ==== verification/access_source_model.sv ====
// Behavioural core and transfer engine that issue single decode requests.
`timescale 1ns/10ps
module access_source_model (
    input  wire logic                clk,
    output memory_map_pkg::access_s  core_access,
    output memory_map_pkg::access_s  dma_access
);
    initial begin
        core_access = '0;
        dma_access = '0;
    end

    // One request per call, full byte address in one word.
    task automatic issue(input logic use_dma, input logic [31:0] a);
        @(posedge clk);
        if (use_dma) begin
            dma_access <= '{valid: 1'b1, addr: a};
        end else begin
            core_access <= '{valid: 1'b1, addr: a};
        end
        @(posedge clk);
        // An idle port shows a scrambled address so a stale one cannot decode by luck.
        core_access <= '{valid: 1'b0, addr: ~a};
        dma_access <= '{valid: 1'b0, addr: ~a};
    endtask : issue
endmodule : access_source_model

// ==== verification/memory_map_address_decoder_tb_top.sv ====
// Self-checking testbench of the memory map address decoder.
`timescale 1ns/10ps
module memory_map_address_decoder_tb_top;
    logic                     clk, srst, psel, penable, pwrite, layout_r, pready, pslverr, qerr;
    logic [4:0]               pins, boot_config_bits;
    logic [31:0]              paddr, pwdata, prdata, q;
    memory_map_pkg::access_s  core_access, dma_access;
    memory_map_pkg::select_s  core_select, dma_select;
    int                       errors, compares;

    access_source_model i_access_source_model (.clk(clk), .core_access(core_access), .dma_access(dma_access));
    memory_map_address_decoder i_memory_map_address_decoder (.clk(clk), .srst(srst), .xbus_data_low_pins(pins),
        .core_access(core_access), .dma_access(dma_access), .core_select(core_select), .dma_select(dma_select),
        .layout_r(layout_r), .boot_config_bits(boot_config_bits), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("Mismatches %0d, comparisons %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // The slave answers in its own time, so the wait is bounded, not fixed.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            finish_test();
        end
    endtask : apb

    // Target code 1F skips the target compare; index 3F means no register selected.
    task automatic dec(input logic use_dma, input logic [31:0] a, input logic [4:0] tgt, input logic [5:0] idx);
        memory_map_pkg::select_s s;
        i_access_source_model.issue(use_dma, a);
        #1;
        s = use_dma ? dma_select : core_select;
        if (tgt != 5'h1F) check({27'h0, s.target}, {27'h0, tgt});
        check({25'h0, s.reg_hit, s.reg_index}, {25'h0, idx != 6'h3F, idx});
    endtask : dec

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        {srst, pins, psel, penable, pwrite, paddr, pwdata, errors, compares} = {1'b1, 5'h15, 3'b000, 64'h0, 64'h0};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({27'h0, boot_config_bits}, 32'h0000_0015);
        check({31'h0, layout_r}, 32'h0000_0001);
        @(posedge clk);
        pins <= 5'h0A;
        dec(0, 32'h0000_0000, 5'h01, 6'h3F);
        dec(0, 32'h0005_FFFC, 5'h01, 6'h3F);
        dec(1, 32'h0006_0000, 5'h00, 6'h3F);
        dec(0, 32'h0140_0000, 5'h03, 6'h3F);
        dec(0, 32'h0200_0000, 5'h04, 6'h3F);
        dec(1, 32'h02FF_FFFC, 5'h04, 6'h3F);
        dec(1, 32'h0300_0000, 5'h05, 6'h3F);
        dec(1, 32'h0400_0000, 5'h00, 6'h3F);
        dec(0, 32'h6000_0000, 5'h12, 6'h3F);
        dec(1, 32'h7FFF_FFFC, 5'h13, 6'h3F);
        dec(0, 32'h019C_01FC, 5'h0D, 6'h3F);
        dec(1, 32'h019C_0200, 5'h0E, 6'h3F);
        dec(0, 32'h01A0_0000, 5'h00, 6'h3F);
        dec(1, 32'h8000_0000, 5'h14, 6'h3F);
        dec(0, 32'h0180_0008, 5'h06, 6'h02);
        dec(1, 32'h0180_0010, 5'h06, 6'h04);
        dec(0, 32'h0180_001C, 5'h06, 6'h07);
        dec(0, 32'h0180_000C, 5'h06, 6'h3F);
        dec(0, 32'h0180_0020, 5'h06, 6'h3F);
        dec(1, 32'h0184_0024, 5'h07, 6'h09);
        dec(0, 32'h0184_0040, 5'h07, 6'h10);
        dec(1, 32'h0184_0064, 5'h07, 6'h19);
        dec(0, 32'h0184_006C, 5'h07, 6'h1B);
        dec(1, 32'h0184_0028, 5'h07, 6'h0A);
        dec(0, 32'h0184_0070, 5'h07, 6'h1C);
        dec(0, 32'h0184_0074, 5'h07, 6'h3F);
        apb(1, memory_map_pkg::global_control_addr, 32'h0000_0000);
        @(posedge clk);
        #1;
        check({31'h0, layout_r}, 32'h0000_0000);
        dec(0, 32'h0000_0000, 5'h02, 6'h3F);
        dec(1, 32'h0006_0000, 5'h02, 6'h3F);
        dec(0, 32'h0100_0000, 5'h03, 6'h3F);
        dec(1, 32'h0140_0000, 5'h01, 6'h3F);
        dec(0, 32'h0146_0000, 5'h00, 6'h3F);
        apb(1, memory_map_pkg::global_control_addr, 32'h0000_0020);
        apb(0, memory_map_pkg::global_control_addr, 32'h0000_0000);
        check(q, 32'h0000_0020);
        check({31'h0, layout_r}, 32'h0000_0001);
        apb(1, 32'h0180_0030, 32'hFFFF_FFFF);
        apb(0, 32'h0180_0030, 32'h0000_0000);
        check(q, 32'h0000_0000);
        check({31'h0, qerr}, 32'h0000_0000);
        apb(1, memory_map_pkg::probe_addr_addr, 32'h0184_0040);
        apb(0, memory_map_pkg::decode_status_addr, 32'h0000_0000);
        check(q & 32'h0000_1FBF, 32'h0000_0790);
        check({27'h0, boot_config_bits}, 32'h0000_0015);
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({27'h0, boot_config_bits}, 32'h0000_000A);
        check({31'h0, layout_r}, 32'h0000_0000);
        dec(0, 32'h0000_0000, 5'h02, 6'h3F);
        finish_test();
    end
endmodule : memory_map_address_decoder_tb_top
